// ===== dv/fcf_flash_model.sv
// Behavioural flash device model seen through the host pins.
`timescale 1ns/1ps
module fcf_flash_model
  import fcf_pkg::*;
#(
  parameter int         AW      = 23,
  parameter int         BUSY_NS = 3000,
  parameter logic [7:0] ID_CODE = 8'h3C   // Arbitrary identifier value.
) (
  // Host pins
  input  wire logic          chip_select_0,
  input  wire logic          chip_select_1,
  input  wire logic          chip_select_2,
  input  wire logic          we_n,
  input  wire logic          oe_n,
  input  wire logic          flash_rst_n,
  input  wire logic          supply_ok,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   dq_bus,
  // Device drive
  output logic [15:0]        dq_dev,
  output logic               dq_dev_oe,
  output logic               busy_indicator
);
  logic [15:0]   mem [int];
  logic [15:0]   bufq [$];
  fcf_mode_e     mode = MODE_ARRAY;
  logic [7:0]    status = 8'h80;
  logic [7:0]    pend = 8'h00;
  logic          busy = 1'b0;
  logic          susp = 1'b0;
  logic          abort_hold = 1'b0;
  logic          armed = 1'b0;
  int            left;
  int            wr_cnt = 0;
  int            lock_cnt = 0;
  realtime       busy_end;
  logic [AW-1:0] base;
  wire           sel = chip_select_2 ? ~(chip_select_1 & chip_select_0)
                                     : ~(chip_select_1 | chip_select_0);

  // Starts an altering operation, or flags it when the supply is at lockout level.
  task automatic launch(output logic ok);
    ok = supply_ok;
    if (!ok) status[3] = 1'b1;
    busy     = ok;
    busy_end = $realtime + BUSY_NS;
  endtask

  // Decodes one latched write against the pending command.
  task automatic take(input logic [AW-1:0] a, input logic [15:0] d);
    logic ok;
    wr_cnt++;
    mode = MODE_STATUS;
    case (pend)
      8'h40, 8'h10: begin
        launch(ok);
        if (ok) mem[a] = d;
        pend = 8'h00;
      end
      8'h20, 8'h60: begin
        if (d[7:0] == 8'hD0 || (pend == 8'h60 && d[7:0] == 8'h01)) begin
          launch(ok);
          if (ok && pend == 8'h20) mem.delete();
          if (ok && pend == 8'h60) lock_cnt = d[0] ? lock_cnt + 1 : 0;
        end else status[5:4] = 2'h3;
        pend = 8'h00;
      end
      8'hE8: begin
        left = int'(d[4:0]) + 1;
        base = a;
        bufq.delete();
        pend = 8'hE9;
      end
      8'hE9: begin
        bufq.push_back(d);
        left--;
        if (left == 0) pend = 8'hEA;
      end
      8'hEA: begin
        if (d[7:0] == 8'hD0) begin
          launch(ok);
          if (ok) foreach (bufq[i]) mem[int'(base) + i] = bufq[i];
        end else status[4] = 1'b1;
        pend = 8'h00;
      end
      default: begin
        case (d[7:0])
          8'hFF: mode = MODE_ARRAY;
          8'h90: mode = MODE_ID;
          8'h98: mode = MODE_QUERY;
          8'h50: status[5:1] = 5'h00;
          8'hB0: begin
            susp = busy;
            busy = 1'b0;
          end
          8'hD0: begin
            busy = busy | susp;
            susp = 1'b0;
          end
          8'h40, 8'h10, 8'h20, 8'h60, 8'hE8: pend = d[7:0];
          default: ;
        endcase
      end
    endcase
  endtask

  // Arms on a selected strobe with outputs off, latches on the earlier rising edge.
  always @(negedge we_n or posedge sel) #1 begin
    if (!we_n && sel && oe_n && flash_rst_n) armed = 1'b1;
  end
  always @(posedge we_n or negedge sel) begin
    if (armed) take(addr, dq_bus);
    armed = 1'b0;
  end

  // Ends the running operation once its time is up, even while deselected.
  always #100 if (busy && $realtime >= busy_end) busy = 1'b0;

  // Reset aborts an operation and holds the busy pin low past the release.
  always @(negedge flash_rst_n) begin
    abort_hold = busy;
    busy       = 1'b0;
    susp       = 1'b0;
    pend       = 8'h00;
  end
  always @(posedge flash_rst_n) begin
    mode   = MODE_ARRAY;
    status = 8'h80;
    #200 abort_hold = 1'b0;
  end

  // Read data by mode; busy status drives a junk pattern beside bit seven.
  function automatic logic [15:0] rd_val(fcf_mode_e m, logic [AW-1:0] a, logic b, logic [7:0] s);
    case (m)
      MODE_ID:     return {8'h00, ID_CODE + {5'h00, a[3:1]}};
      MODE_QUERY:  return 16'h0051;
      MODE_STATUS: return b ? 16'hA55A : {8'h00, s};
      default:     return mem.exists(a) ? mem[a] : 16'hFFFF;
    endcase
  endfunction

  // Pins float unless selected for a read outside power-down.
  assign dq_dev_oe      = sel && !oe_n && flash_rst_n;
  assign dq_dev         = rd_val(mode, addr, busy, status);
  assign busy_indicator = ~(busy | abort_hold);
endmodule

// ===== dv/fcf_host_bench.sv
// Self-checking bench for the flash host controller against a flash model.
`timescale 1ns/1ps
module fcf_host_bench;
  import fcf_pkg::*;
  logic        clk_sys, rstn, cmd_valid, wdata_valid, word_mode, supply_ok;
  fcf_op_e     cmd_op;
  logic [22:0] cmd_addr, addr;
  logic [15:0] cmd_data, wdata, rdata, dq_out, dq_dev, dq_last = 16'h0000;
  logic [4:0]  cmd_count;
  logic        cmd_ready, done, err, need_data, we_n, oe_n, flash_rst_n, dq_oe, dq_dev_oe;
  logic        chip_select_0, chip_select_1, chip_select_2, busy_indicator;
  int          error_cnt = 0, num_checks = 0, lat, widx;
  wire  [15:0] dq_in = dq_dev_oe ? dq_dev : (dq_oe ? dq_out : ~dq_last);

  fcf_host #(.RST_LOW_CNT(3), .RST_BSY_CNT(4), .RST_WR_CNT(3)) DUT (.clk_sys, .rstn,
    .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_count, .cmd_ready, .done, .err, .rdata,
    .need_data, .wdata_valid, .wdata, .word_mode, .supply_ok, .chip_select_0,
    .chip_select_1, .chip_select_2, .we_n, .oe_n, .flash_rst_n, .addr, .dq_out, .dq_oe,
    .dq_in, .busy_indicator);
  fcf_flash_model FLASH (.chip_select_0, .chip_select_1, .chip_select_2, .we_n, .oe_n,
    .flash_rst_n, .supply_ok, .addr, .dq_bus(dq_in), .dq_dev, .dq_dev_oe, .busy_indicator);

  // Clock, released-bus memory and buffer word feeder.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) dq_last <= dq_in;
  always @(posedge clk_sys) if (need_data && wdata_valid) widx <= widx + 1;
  always @(negedge clk_sys) begin
    wdata_valid = need_data;
    wdata       = 16'hB000 + 16'(widx);
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Issues one operation and waits, bounded, for its done pulse.
  task automatic run_op(fcf_op_e o, logic [22:0] a, logic [15:0] d, logic [4:0] n);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op    = o;
    cmd_addr  = a;
    cmd_data  = d;
    cmd_count = n;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    lat       = 0;
    while (done !== 1'b1 && lat < 3000) begin
      @(negedge clk_sys);
      lat++;
    end
    chk("done seen", 16'h0001, {15'h0000, done});
  endtask

  task automatic op(fcf_op_e o, logic [22:0] a);
    run_op(o, a, 16'h0000, 5'h00);
  endtask

  task automatic wait_idle();
    int k = 0;
    while (busy_indicator !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_prog();
    int w = FLASH.wr_cnt;
    run_op(OP_PROG, 23'h000100, 16'h1234, 5'h00);
    chk("prog writes", 16'h0002, 16'(FLASH.wr_cnt - w));
    op(OP_READ, 23'h000100);
    chk("busy status", 16'h0000, rdata);
    chk("busy pin", 16'h0000, {15'h0000, busy_indicator});
    wait_idle();
    op(OP_READ, 23'h000100);
    chk("idle status", 16'h0080, rdata);
    op(OP_SET_ARRAY, 23'h000000);
    op(OP_READ, 23'h000100);
    chk("array data", 16'h1234, rdata);
    $display("test prog finished");
  endtask

  task automatic t_modes();
    op(OP_SET_ID, 23'h000000);
    op(OP_READ, 23'h000002);
    chk("id even", 16'h003D, rdata);
    op(OP_READ, 23'h000003);
    chk("id odd", 16'h003D, rdata);
    op(OP_SET_QUERY, 23'h000000);
    op(OP_READ, 23'h000010);
    chk("query", 16'h0051, rdata);
    // Clearing and then selecting status reads back the idle ready value.
    op(OP_CLR_STATUS, 23'h000000);
    op(OP_SET_STATUS, 23'h000000);
    op(OP_READ, 23'h000004);
    chk("status mode", 16'h0080, rdata);
    $display("test modes finished");
  endtask

  task automatic t_lockout();
    int w = FLASH.wr_cnt;
    supply_ok = 1'b0;
    op(OP_ERASE, 23'h000100);
    chk("lockout err", 16'h0001, {15'h0000, err});
    chk("lockout latency", 16'h0000, 16'(lat));
    chk("lockout writes", 16'h0000, 16'(FLASH.wr_cnt - w));
    op(OP_SET_ID, 23'h000000);
    chk("lockout read ok", 16'h0000, {15'h0000, err});
    supply_ok = 1'b1;
    $display("test lockout finished");
  endtask

  task automatic t_erase_buf();
    op(OP_ERASE, 23'h000100);
    wait_idle();
    op(OP_SET_ARRAY, 23'h000000);
    op(OP_READ, 23'h000100);
    chk("erased", 16'hFFFF, rdata);
    widx = 0;
    run_op(OP_BUF_PROG, 23'h000200, 16'h0000, 5'h10);
    chk("count refused", 16'h0001, {15'h0000, err});
    run_op(OP_BUF_PROG, 23'h000200, 16'h0000, 5'h0F);
    chk("count ok", 16'h0000, {15'h0000, err});
    chk("words sent", 16'h0010, 16'(widx));
    wait_idle();
    op(OP_SET_ARRAY, 23'h000000);
    op(OP_READ, 23'h00020F);
    chk("buffer last", 16'hB00F, rdata);
    $display("test erase and buffer finished");
  endtask

  task automatic t_lock_susp();
    op(OP_LOCK_SET, 23'h020000);
    chk("lock set", 16'h0001, 16'(FLASH.lock_cnt));
    wait_idle();
    op(OP_LOCK_CLR, 23'h000000);
    chk("lock clear", 16'h0000, 16'(FLASH.lock_cnt));
    wait_idle();
    run_op(OP_PROG, 23'h000300, 16'h5555, 5'h00);
    op(OP_SUSPEND, 23'h000000);
    chk("suspended", 16'h0001, {15'h0000, busy_indicator});
    op(OP_RESUME, 23'h000000);
    chk("resumed", 16'h0000, {15'h0000, busy_indicator});
    $display("test lock and suspend finished");
  endtask

  task automatic t_reset();
    op(OP_RESET, 23'h000000);
    chk("reset err", 16'h0000, {15'h0000, err});
    chk("aborted", 16'h0001, {15'h0000, busy_indicator});
    chk("status after", 16'h0080, {8'h00, FLASH.status});
    op(OP_READ, 23'h00020F);
    chk("array after", 16'hB00F, rdata);
    $display("test reset finished");
  endtask

  // Main sequence.
  initial begin
    rstn        = 1'b0;
    cmd_valid   = 1'b0;
    cmd_op      = OP_READ;
    cmd_addr    = 23'h000000;
    cmd_data    = 16'h0000;
    cmd_count   = 5'h00;
    word_mode   = 1'b1;
    supply_ok   = 1'b1;
    widx        = 0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    chk("idle pins", 16'h0019, {11'h000, we_n, oe_n, chip_select_2, chip_select_1,
      chip_select_0});
    t_prog();
    t_modes();
    t_lockout();
    t_erase_buf();
    t_lock_susp();
    t_reset();
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    #(20000 * 100);
    error_cnt++;
    end_sim();
  end
endmodule

// ===== verilog/fcf_host.sv
// Host controller that drives a parallel flash through its command pins.
`timescale 1ns/1ps
module fcf_host
  import fcf_pkg::*;
#(
  parameter int AW          = 23,
  parameter int RST_LOW_CNT = RST_LOW_CYC,
  parameter int RST_BSY_CNT = RST_BSY_CYC,
  parameter int RST_WR_CNT  = RST_WR_CYC
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // Command port
  input  wire logic          cmd_valid,
  input  wire fcf_op_e       cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [15:0]   cmd_data,
  input  wire logic [4:0]    cmd_count,
  output logic               cmd_ready,
  output logic               done,
  output logic               err,
  output logic [15:0]        rdata,
  // Buffer data stream
  output logic               need_data,
  input  wire logic          wdata_valid,
  input  wire logic [15:0]   wdata,
  // Configuration levels
  input  wire logic          word_mode,
  input  wire logic          supply_ok,
  // Flash pins
  output logic               chip_select_0,
  output logic               chip_select_1,
  output logic               chip_select_2,
  output logic               we_n,
  output logic               oe_n,
  output logic               flash_rst_n,
  output logic [AW-1:0]      addr,
  output logic [15:0]        dq_out,
  output logic               dq_oe,
  input  wire logic [15:0]   dq_in,
  input  wire logic          busy_indicator
);

  // ----------------------------------------------------------------------
  // Parameter check and state
  // ----------------------------------------------------------------------
  if (RST_LOW_CNT < 1 || RST_LOW_CNT > 511 || RST_BSY_CNT < 1 || RST_BSY_CNT > 511 ||
      RST_WR_CNT < 1 || RST_WR_CNT > 511 || AW < 8) begin : g_bad
    $error("fcf_host parameter out of range");
  end

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_WSETUP = 10'h002, ST_WPULSE = 10'h004, ST_WHOLD = 10'h008,
    ST_RACC = 10'h010, ST_NEXT = 10'h020, ST_DATA = 10'h040, ST_RLOW = 10'h080,
    ST_RBUSY = 10'h100, ST_RREC = 10'h200
  } fcf_state_e;

  fcf_state_e      state_reg;
  fcf_op_e         op_reg;
  fcf_mode_e       mode_reg;
  logic [AW-1:0]   addr_reg, waddr_reg;
  logic [15:0]     data_reg, wbuf_reg, rd_reg;
  logic [4:0]      cnt_reg;
  logic [5:0]      step_reg;
  logic            polled_reg, wcmd_reg;
  logic [2:0]      ce_reg;
  logic            tmr_start;
  logic [8:0]      tmr_load;
  logic            tmr_done;
  logic [5:0]      last_step;
  logic            alter_op;

  // Operations that alter the array, refused under lockout supply.
  assign alter_op  = cmd_op inside {OP_PROG, OP_BUF_PROG, OP_ERASE, OP_LOCK_SET, OP_LOCK_CLR};
  assign last_step = 6'({1'b0, cnt_reg}) + 6'd3;
  assign {chip_select_2, chip_select_1, chip_select_0} = ce_reg;

  fcf_timer #(.W(9)) u_timer (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (tmr_start),
    .load    (tmr_load),
    .expired (tmr_done)
  );

  // ----------------------------------------------------------------------
  // Sequencer: command port, pin phases and multi-cycle command sequences
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;   op_reg   <= OP_READ;   mode_reg <= MODE_ARRAY;
      addr_reg  <= '0;        waddr_reg <= '0;       data_reg <= 16'h0000;
      wbuf_reg  <= 16'h0000;  rd_reg   <= 16'h0000;  cnt_reg  <= 5'h00;
      step_reg  <= 6'h00;     polled_reg <= 1'b0;    wcmd_reg <= 1'b0;
      ce_reg    <= CE_OFF;    we_n     <= 1'b1;      oe_n     <= 1'b1;
      flash_rst_n <= 1'b1;    addr     <= '0;        dq_out   <= 16'h0000;
      dq_oe     <= 1'b0;      cmd_ready <= 1'b1;     done     <= 1'b0;
      err       <= 1'b0;      rdata    <= 16'h0000;  need_data <= 1'b0;
      tmr_start <= 1'b0;      tmr_load <= 9'h000;
    end else begin
      done      <= 1'b0;
      tmr_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            err <= 1'b0;
            op_reg <= cmd_op;
            addr_reg <= cmd_addr;
            data_reg <= cmd_data;
            cnt_reg <= cmd_count;
            step_reg <= 6'h00;
            polled_reg <= 1'b0;
            waddr_reg <= cmd_addr;
            wcmd_reg <= 1'b1;
            if (alter_op && !supply_ok) begin
              err <= 1'b1;
              done <= 1'b1;
              cmd_ready <= 1'b1;
            end else if (cmd_op == OP_BUF_PROG &&
                         cmd_count > (word_mode ? CNT_MAX_WORD : CNT_MAX_BYTE)) begin
              err <= 1'b1;
              done <= 1'b1;
              cmd_ready <= 1'b1;
            end else if (cmd_op == OP_READ) begin
              ce_reg <= CE_ON;
              addr <= cmd_addr;
              oe_n <= 1'b0;
              tmr_load <= 9'(ACC_CYC);
              tmr_start <= 1'b1;
              state_reg <= ST_RACC;
            end else if (cmd_op == OP_RESET) begin
              flash_rst_n <= 1'b0;
              tmr_load <= 9'(RST_LOW_CNT);
              tmr_start <= 1'b1;
              state_reg <= ST_RLOW;
            end else begin
              // First cycle code; the upper byte stays zero in command writes.
              case (cmd_op)
                OP_SET_ARRAY:  wbuf_reg <= {8'h00, CMD_READ_ARRAY};
                OP_SET_ID:     wbuf_reg <= {8'h00, CMD_READ_ID};
                OP_SET_QUERY:  wbuf_reg <= {8'h00, CMD_READ_QUERY};
                OP_SET_STATUS: wbuf_reg <= {8'h00, CMD_READ_STAT};
                OP_CLR_STATUS: wbuf_reg <= {8'h00, CMD_CLR_STAT};
                OP_PROG:       wbuf_reg <= {8'h00, CMD_PROG};
                OP_BUF_PROG:   wbuf_reg <= {8'h00, CMD_BUF_PROG};
                OP_ERASE:      wbuf_reg <= {8'h00, CMD_ERASE};
                OP_SUSPEND:    wbuf_reg <= {8'h00, CMD_SUSPEND};
                OP_RESUME:     wbuf_reg <= {8'h00, CMD_CONFIRM};
                default:       wbuf_reg <= {8'h00, CMD_LOCK_SETUP};
              endcase
              state_reg <= ST_WSETUP;
            end
          end
        end
        ST_WSETUP: begin
          // Address, data and select settle while output enable stays high.
          ce_reg <= CE_ON;
          addr <= waddr_reg;
          dq_out <= wbuf_reg;
          dq_oe <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b0;
          tmr_load <= 9'(WE_CYC);
          tmr_start <= 1'b1;
          state_reg <= ST_WPULSE;
        end
        ST_WPULSE: begin
          if (tmr_done) begin
            we_n <= 1'b1;  // Strobe rises first, so the latch edge is the strobe's.
            state_reg <= ST_WHOLD;
          end
        end
        ST_WHOLD: begin
          ce_reg <= CE_OFF;
          dq_oe <= 1'b0;
          step_reg <= step_reg + 6'd1;
          state_reg <= ST_NEXT;
        end
        ST_RACC: begin
          if (tmr_done) begin
            rd_reg <= dq_in;
            oe_n <= 1'b1;
            ce_reg <= CE_OFF;
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          state_reg <= ST_WSETUP;
          wcmd_reg <= 1'b1;
          waddr_reg <= addr_reg;
          case (op_reg)
            OP_PROG: begin
              wbuf_reg <= data_reg;
              wcmd_reg <= 1'b0;
            end
            OP_ERASE, OP_LOCK_CLR: wbuf_reg <= {8'h00, CMD_CONFIRM};
            OP_LOCK_SET:           wbuf_reg <= {8'h00, CMD_LOCK_SET};
            OP_BUF_PROG: begin
              wbuf_reg <= {8'h00, CMD_CONFIRM};
              if (step_reg == 6'd1 && !(polled_reg && rd_reg[READY_BIT])) begin
                polled_reg <= 1'b1;  // Read extended_status until a buffer is free.
                ce_reg <= CE_ON;
                addr <= addr_reg;
                oe_n <= 1'b0;
                tmr_load <= 9'(ACC_CYC);
                tmr_start <= 1'b1;
                state_reg <= ST_RACC;
              end else if (step_reg == 6'd1) begin
                wbuf_reg <= {11'h000, cnt_reg};
              end else if (step_reg < last_step) begin
                need_data <= 1'b1;
                state_reg <= ST_DATA;
              end
            end
            default: wbuf_reg <= 16'h0000;
          endcase
          // Sequence end: the last write (data, confirm or lock code) has gone out or the op had one cycle.
          if ((op_reg == OP_READ) || (op_reg == OP_PROG && step_reg == 6'd2) ||
              (op_reg inside {OP_ERASE, OP_LOCK_SET, OP_LOCK_CLR} && step_reg == 6'd2) ||
              (op_reg == OP_BUF_PROG && step_reg > last_step) ||
              (op_reg inside {OP_SET_ARRAY, OP_SET_ID, OP_SET_QUERY, OP_SET_STATUS,
                              OP_CLR_STATUS, OP_SUSPEND, OP_RESUME})) begin
            state_reg <= ST_IDLE;
            tmr_start <= 1'b0;
            done <= 1'b1;
            cmd_ready <= 1'b1;
          end
          // Returned data in the current read mode.
          if (op_reg == OP_READ) begin
            if (mode_reg == MODE_STATUS && !busy_indicator) begin
              rdata <= {8'h00, rd_reg[7], 7'h00};
            end else if (word_mode && (mode_reg == MODE_ID || mode_reg == MODE_QUERY)) begin
              rdata <= {8'h00, rd_reg[7:0]};
            end else begin
              rdata <= rd_reg;
            end
          end
          // Mode that the device now answers reads in.
          case (op_reg)
            OP_SET_ARRAY: mode_reg <= MODE_ARRAY;
            OP_SET_ID:    mode_reg <= MODE_ID;
            OP_SET_QUERY: mode_reg <= MODE_QUERY;
            OP_READ:      mode_reg <= mode_reg;
            default:      mode_reg <= (op_reg == OP_RESUME) ? mode_reg : MODE_STATUS;
          endcase
        end
        ST_DATA: begin
          if (wdata_valid) begin
            need_data <= 1'b0;
            wbuf_reg <= wdata;
            wcmd_reg <= 1'b0;
            waddr_reg <= addr_reg + AW'(step_reg - 6'd2);
            state_reg <= ST_WSETUP;
          end
        end
        ST_RLOW: begin
          if (tmr_done) begin
            flash_rst_n <= 1'b1;
            mode_reg <= MODE_ARRAY;
            tmr_load <= 9'(RST_BSY_CNT);
            tmr_start <= 1'b1;
            state_reg <= ST_RBUSY;
          end
        end
        ST_RBUSY: begin
          // busy_indicator must rise within the reset window.
          if (busy_indicator || tmr_done) begin
            err <= !busy_indicator;
            tmr_load <= 9'(RST_WR_CNT);
            tmr_start <= 1'b1;
            state_reg <= ST_RREC;
          end
        end
        ST_RREC: begin
          if (tmr_done) begin
            done <= 1'b1;
            cmd_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  write_strobe_a: assert property (!we_n |-> oe_n && ce_reg == CE_ON)
    else $error("write strobe low without select or with output enabled");
  strobe_first_a: assert property ($rose(we_n) |-> ce_reg == CE_ON ##1 ce_reg == CE_OFF)
    else $error("select did not stay on past the strobe rise");
  no_contend_a: assert property (dq_oe |-> oe_n)
    else $error("data driven while output enable is low");
  cmd_upper_a: assert property (dq_oe && wcmd_reg |-> dq_out[15:8] == 8'h00)
    else $error("command write with nonzero upper byte");
  recovery_a: assert property ($rose(flash_rst_n) |-> we_n [*8])
    else $error("write too soon after reset release");
  lockout_a: assert property (state_reg == ST_IDLE && cmd_valid && cmd_ready && alter_op &&
                              !supply_ok |=> err && done && state_reg == ST_IDLE)
    else $error("altering command not refused under lockout supply");
  count_a: assert property (state_reg == ST_IDLE && cmd_valid && cmd_ready &&
                            cmd_op == OP_BUF_PROG && word_mode && cmd_count > 5'h0F
                            |=> err && done)
    else $error("oversized buffer count accepted");
  confirm_a: assert property (state_reg == ST_WSETUP && op_reg == OP_BUF_PROG &&
                              step_reg == last_step |=> dq_out[7:0] == CMD_CONFIRM)
    else $error("buffer sequence did not end in confirm");
  poll_a: assert property (state_reg == ST_WSETUP && op_reg == OP_BUF_PROG &&
                           step_reg == 6'd1 |-> polled_reg && rd_reg[READY_BIT])
    else $error("count sent before a free buffer was seen");

  prog_c: cover property (state_reg == ST_NEXT && op_reg == OP_PROG && done == 1'b0 ##1 done);
  buf_c: cover property (op_reg == OP_BUF_PROG && state_reg == ST_NEXT ##1 done);
  reset_c: cover property (state_reg == ST_RREC ##1 done);
  lock_c: cover property (state_reg == ST_IDLE && err && op_reg == OP_ERASE);

endmodule

// ===== verilog/fcf_pkg.sv
// Package with command codes, pin levels and timing counts for the flash host controller.
package fcf_pkg;

  // ----------------------------------------------------------------------
  // Command codes written to the command_front_end
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0] CMD_BUF_PROG   = 8'hE8;
  localparam logic [7:0] CMD_PROG       = 8'h40;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET   = 8'h01;

  // ----------------------------------------------------------------------
  // Pin levels and field positions
  // ----------------------------------------------------------------------
  localparam logic [2:0] CE_ON          = 3'h0;  // {cs2, cs1, cs0} enabled.
  localparam logic [2:0] CE_OFF         = 3'h1;  // Only cs0 high: disabled.
  localparam int         READY_BIT      = 7;     // Buffer free / machine ready.
  localparam logic [4:0] CNT_MAX_BYTE   = 5'h1F;
  localparam logic [4:0] CNT_MAX_WORD   = 5'h0F;

  // ----------------------------------------------------------------------
  // Timing at a 100 ns clock
  // ----------------------------------------------------------------------
  localparam int CLK_NS       = 100;
  localparam int T_WE_NS      = 70;     // Least write strobe low time.
  localparam int T_ACC_NS     = 120;    // Least read access time.
  localparam int T_RST_LOW_NS = 25000;  // reset_low_width.
  localparam int T_RST_BSY_NS = 100;    // reset_recovery_busy.
  localparam int T_RST_WR_NS  = 1000;   // reset_to_write_delay.
  localparam int WE_CYC       = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC  = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_BSY_CYC  = (T_RST_LOW_NS + T_RST_BSY_NS) / CLK_NS;
  localparam int RST_WR_CYC   = (T_RST_WR_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------------
  // Operations on the command port and read modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ, OP_SET_ARRAY, OP_SET_ID, OP_SET_QUERY, OP_SET_STATUS, OP_CLR_STATUS,
    OP_PROG, OP_BUF_PROG, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_LOCK_SET,
    OP_LOCK_CLR, OP_RESET
  } fcf_op_e;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_QUERY, MODE_STATUS} fcf_mode_e;

endpackage

// ===== verilog/fcf_timer.sv
// Down counter that times pin phases in clock cycles.
`timescale 1ns/1ps
module fcf_timer #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              expired
);

  logic [W-1:0] count_reg;

  // Loads on start and counts down to zero.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= load;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // Expiry is hidden in the cycle that starts a new count.
  assign expired = (count_reg == '0) && !start;

endmodule
